// file: hw/cmd_in_filter.sv
`timescale 1ns/10ps
`default_nettype none
module cmd_in_filter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic level
);
	import pio_point_pkg::*;

	typedef struct packed {
		logic [2:0] sync;
		logic [DEB_W-1:0] cnt;
		logic lvl;
	} flt_t;

	flt_t r;
	flt_t n;

	// A bounce restarts the count, so a level must hold for the whole time
	always_comb begin
		n = r;
		n.sync = {r.sync[1:0], pin};
		if (r.sync[2] != r.sync[1] || r.sync[2] == r.lvl) begin
			n.cnt = '0;
		end else if (r.cnt == DEB_LAST) begin
			n.cnt = '0;
			n.lvl = r.sync[2];
		end else begin
			n.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign level = r.lvl;
endmodule // cmd_in_filter
`default_nettype wire

// file: hw/event_irq.sv
`timescale 1ns/10ps
`default_nettype none
module event_irq (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [pio_point_pkg::EV_W-1:0] ev,
	input wire logic clr_we,
	input wire logic mask_we,
	input wire logic [pio_point_pkg::EV_W-1:0] wdata,
	output logic [pio_point_pkg::EV_W-1:0] stat,
	output logic [pio_point_pkg::EV_W-1:0] mask,
	output logic irq
);
	import pio_point_pkg::*;

	typedef struct packed {
		logic [EV_W-1:0] stat;
		logic [EV_W-1:0] mask;
		logic irq;
	} irq_st_t;

	irq_st_t r;
	irq_st_t n;

	always_comb begin
		n = r;
		// A new event wins over a write-one-to-clear in the same cycle
		n.stat = (r.stat & ~(clr_we ? wdata : '0)) | ev;
		if (mask_we) begin
			n.mask = wdata;
		end
		n.irq = |(n.stat & n.mask);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '{stat: '0, mask: RST_INT_MASK, irq: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign stat = r.stat;
	assign mask = r.mask;
	assign irq = r.irq;
endmodule // event_irq
`default_nettype wire

// file: hw/pio_point_move_interface.sv
`timescale 1ns/10ps
`default_nettype none
module pio_point_move_interface (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [pio_point_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic move_cmd_a,
	input wire logic move_cmd_b,
	input wire logic alarm_clear_in,
	input wire logic [pio_point_pkg::POS_W-1:0] cur_pos,
	input wire logic motion_busy,
	input wire logic move_complete,
	input wire logic home_complete,
	input wire logic fault_event,
	output logic move_start_out,
	output logic [pio_point_pkg::POS_W-1:0] target_pos_out,
	output logic stop_out,
	output logic start_zone_out,
	output logic end_zone_out,
	output logic mid_zone_out,
	output logic start_arrived_out,
	output logic end_arrived_out,
	output logic mid_arrived_out,
	output logic homing_done_out,
	output logic fault_n_out
);
	import pio_point_pkg::*;

	typedef struct packed {
		pat_t pattern;
		logic mid_off;
		logic sel_complete;
		logic [POS_W-1:0] pos_start;
		logic [POS_W-1:0] pos_end;
		logic [POS_W-1:0] pos_mid;
		logic [POS_W-1:0] width;
		cmd_t last_cmd;
		pt_t target;
		logic [2:0] arrived;
		logic alarm;
		logic homed;
		logic clr_seen;
		logic waitreq;
		logic [31:0] rdata;
		logic move_start;
		logic [POS_W-1:0] tgt_pos;
		logic stop;
		logic [2:0] zone_o;
		logic [2:0] arr_o;
		logic home_o;
		logic fault_n;
		logic [EV_W-1:0] ev;
	} st_t;

	st_t r;
	st_t n;

	logic cmd_a;
	logic cmd_b;
	logic clr_lvl;
	logic commit_wr;
	logic clr_we;
	logic mask_we;
	logic [EV_W-1:0] int_stat;
	logic [EV_W-1:0] int_mask;

	function automatic cmd_t decode_cmd(input pat_t p, input logic off,
			input logic a, input logic b);
		cmd_t c;
		c = CMD_HOLD;
		unique case (p)
			PAT_SINGLE: begin
				c = a ? CMD_END : CMD_START;
			end
			PAT_TWO_POINT: begin
				unique case ({a, b})
					2'b10: c = CMD_START;
					2'b01: c = CMD_END;
					2'b11: c = CMD_MID;
					// Both OFF keeps the last move; re-pressing the same one repeats it
					2'b00: c = CMD_HOLD;
				endcase
			end
			PAT_THREE_POINT: begin
				unique case ({a, b})
					2'b10: c = CMD_START;
					2'b01: c = CMD_END;
					2'b11: c = off ? CMD_STOP : CMD_MID;
					2'b00: c = off ? CMD_MID : CMD_STOP;
				endcase
			end
			default: begin
				c = CMD_HOLD;
			end
		endcase
		return c;
	endfunction

	function automatic logic in_zone(input logic [POS_W-1:0] pos,
			input logic [POS_W-1:0] pt, input logic [POS_W-1:0] w);
		logic [POS_W-1:0] d;
		d = (pos >= pt) ? pos - pt : pt - pos;
		return d <= w;
	endfunction

	function automatic logic [POS_W-1:0] be16(input logic [POS_W-1:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic pt_t cmd_point(input cmd_t c);
		pt_t p;
		p = PT_START;
		if (c == CMD_END) begin
			p = PT_END;
		end else if (c == CMD_MID) begin
			p = PT_MID;
		end
		return p;
	endfunction

	cmd_in_filter u_flt_a (
		.clk(clk),
		.rst_n(rst_n),
		.pin(move_cmd_a),
		.level(cmd_a)
	);

	cmd_in_filter u_flt_b (
		.clk(clk),
		.rst_n(rst_n),
		.pin(move_cmd_b),
		.level(cmd_b)
	);

	cmd_in_filter u_flt_clr (
		.clk(clk),
		.rst_n(rst_n),
		.pin(alarm_clear_in),
		.level(clr_lvl)
	);

	// A write lands at the edge where the master sees waitrequest low
	assign commit_wr = !r.waitreq && avs_write;
	assign clr_we = commit_wr && avs_address == OFS_INT_STAT && avs_byteenable[0];
	assign mask_we = commit_wr && avs_address == OFS_INT_MASK && avs_byteenable[0];

	event_irq u_irq (
		.clk(clk),
		.rst_n(rst_n),
		.ev(r.ev),
		.clr_we(clr_we),
		.mask_we(mask_we),
		.wdata(avs_writedata[EV_W-1:0]),
		.stat(int_stat),
		.mask(int_mask),
		.irq(irq)
	);

	always_comb begin
		cmd_t cmd;
		pt_t pt;
		logic [31:0] rd;
		logic two_in;
		cmd = decode_cmd(r.pattern, r.mid_off, cmd_a, cmd_b);
		pt = cmd_point(cmd);
		rd = '0;
		two_in = r.pattern != PAT_SINGLE;
		n = r;
		n.move_start = 1'b0;
		n.stop = 1'b0;
		n.ev = '0;

		// Alarm clear acts once per ON level, so a held input cannot mask new faults
		n.clr_seen = clr_lvl;
		if (clr_lvl && !r.clr_seen) begin
			n.alarm = 1'b0;
		end
		if (fault_event) begin
			n.alarm = 1'b1;
			n.ev[EV_ALARM] = !r.alarm;
		end

		// Commands are ignored during an alarm; a change made meanwhile acts after clear
		if (!r.alarm && cmd != r.last_cmd) begin
			n.last_cmd = cmd;
			unique case (cmd)
				CMD_HOLD: begin
					n.last_cmd = CMD_HOLD;
				end
				CMD_STOP: begin
					n.stop = motion_busy;
				end
				CMD_START, CMD_END, CMD_MID: begin
					n.target = pt;
					n.move_start = 1'b1;
					n.ev[EV_MOVE] = 1'b1;
					unique case (pt)
						PT_START: n.tgt_pos = r.pos_start;
						PT_END: n.tgt_pos = r.pos_end;
						PT_MID: n.tgt_pos = r.pos_mid;
					endcase
					n.arrived = r.arrived & (3'b001 << pt);
				end
			endcase
		end

		// Completion belongs to the old target even if a new move is taken now
		if (move_complete) begin
			n.arrived[r.target] = 1'b1;
			n.ev[EV_ARRIVE] = 1'b1;
		end

		n.homed = home_complete;
		if (home_complete && !r.homed) begin
			n.ev[EV_HOME] = 1'b1;
		end

		// Zone and arrival share pins, so only the selected kind is driven
		n.zone_o[0] = !r.sel_complete && in_zone(cur_pos, r.pos_start, r.width);
		n.zone_o[1] = !r.sel_complete && in_zone(cur_pos, r.pos_end, r.width);
		n.zone_o[2] = !r.sel_complete && two_in
			&& in_zone(cur_pos, r.pos_mid, r.width);
		n.arr_o[0] = r.sel_complete && n.arrived[0];
		n.arr_o[1] = r.sel_complete && n.arrived[1];
		n.arr_o[2] = r.sel_complete && two_in && n.arrived[2];
		n.home_o = !two_in && n.homed;
		n.fault_n = !n.alarm;

		unique case (avs_address)
			OFS_CTRL: begin
				rd[CTRL_PAT_LSB +: 2] = r.pattern;
				rd[CTRL_MIDOFF_BIT] = r.mid_off;
				rd[CTRL_SEL_BIT] = r.sel_complete;
			end
			OFS_POS_START: rd[POS_W-1:0] = r.pos_start;
			OFS_POS_END: rd[POS_W-1:0] = r.pos_end;
			OFS_POS_MID: rd[POS_W-1:0] = r.pos_mid;
			OFS_WIDTH: rd[POS_W-1:0] = r.width;
			OFS_STATUS: begin
				rd[ST_TGT_LSB +: 2] = r.target;
				rd[ST_ALARM_BIT] = r.alarm;
				rd[ST_HOMED_BIT] = r.homed;
				rd[ST_BUSY_BIT] = motion_busy;
				rd[ST_CMDA_BIT] = cmd_a;
				rd[ST_CMDB_BIT] = cmd_b;
				rd[ST_ARR_LSB +: 3] = r.arrived;
				rd[ST_ZONE_LSB +: 3] = r.zone_o;
			end
			OFS_INT_STAT: rd[EV_W-1:0] = int_stat;
			OFS_INT_MASK: rd[EV_W-1:0] = int_mask;
			default: rd = '0;
		endcase

		// Every access costs one wait cycle, so read data comes from a register
		if (r.waitreq) begin
			if (avs_read || avs_write) begin
				n.waitreq = 1'b0;
				n.rdata = avs_read ? rd : '0;
			end
		end else begin
			n.waitreq = 1'b1;
			if (avs_write) begin
				unique case (avs_address)
					OFS_CTRL: begin
						if (avs_byteenable[0]) begin
							n.pattern = pat_t'(avs_writedata[CTRL_PAT_LSB +: 2]);
							n.mid_off = avs_writedata[CTRL_MIDOFF_BIT];
							n.sel_complete = avs_writedata[CTRL_SEL_BIT];
						end
					end
					OFS_POS_START: begin
						n.pos_start = be16(r.pos_start, avs_writedata, avs_byteenable);
					end
					OFS_POS_END: begin
						n.pos_end = be16(r.pos_end, avs_writedata, avs_byteenable);
					end
					OFS_POS_MID: begin
						n.pos_mid = be16(r.pos_mid, avs_writedata, avs_byteenable);
					end
					OFS_WIDTH: begin
						n.width = be16(r.width, avs_writedata, avs_byteenable);
					end
					default: begin
						n.waitreq = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '{
				pattern: PAT_SINGLE,
				mid_off: 1'b0,
				sel_complete: 1'b0,
				pos_start: RST_POS_START,
				pos_end: RST_POS_END,
				pos_mid: RST_POS_MID,
				width: RST_WIDTH,
				last_cmd: CMD_HOLD,
				target: PT_START,
				arrived: 3'h0,
				alarm: 1'b0,
				homed: 1'b0,
				clr_seen: 1'b0,
				waitreq: 1'b1,
				rdata: 32'h0,
				move_start: 1'b0,
				tgt_pos: RST_POS_START,
				stop: 1'b0,
				zone_o: 3'h0,
				arr_o: 3'h0,
				home_o: 1'b0,
				fault_n: 1'b1,
				ev: 4'h0
			};
		end else begin
			r <= n;
		end
	end

	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.waitreq;
	assign move_start_out = r.move_start;
	assign target_pos_out = r.tgt_pos;
	assign stop_out = r.stop;
	assign start_zone_out = r.zone_o[0];
	assign end_zone_out = r.zone_o[1];
	assign mid_zone_out = r.zone_o[2];
	assign start_arrived_out = r.arr_o[0];
	assign end_arrived_out = r.arr_o[1];
	assign mid_arrived_out = r.arr_o[2];
	assign homing_done_out = r.home_o;
	assign fault_n_out = r.fault_n;
endmodule // pio_point_move_interface
`default_nettype wire

// file: hw/pio_point_pkg.sv
// How it works
// - Single-input pattern: command A ON starts a move to the end point.
// - Single-input pattern: command A OFF starts a move to the start point.
// - Two-input patterns: A OFF with B ON moves to the end point.
// - Two-input patterns: A ON with B OFF moves to the start point.
// - Two-input two-point pattern: both commands ON moves to the intermediate point.
// - Three-point, both-ON setting: both ON goes mid, both OFF stops motion.
// - Three-point, both-OFF setting: both OFF goes mid, both ON stops motion.
// - Alarm-clear input at ON clears an active alarm.
// - Zone outputs are ON while position lies within the width of the point.
// - Arrival outputs turn ON when pressing or positioning to that point completes.
// - An arrival output turns OFF once a move elsewhere is accepted.
// - Homing-done output turns ON once home return has finished.
// - No homing-done output in two-input patterns; pin carries mid output.
// - Fault output is ON in normal condition, OFF in alarm.
// - Active-low signals act when OFF; such outputs idle ON, drop when asserted.
package pio_point_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int DEB_TIME_NS = 2000;
	localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_W = 9;
	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYC - 1);
	localparam int POS_W = 16;
	localparam int ADDR_W = 5;
	localparam int EV_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_POS_START = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_POS_END = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_POS_MID = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_WIDTH = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_INT_STAT = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK = 5'h1c;
	localparam int CTRL_PAT_LSB = 0;
	localparam int CTRL_MIDOFF_BIT = 2;
	localparam int CTRL_SEL_BIT = 3;
	localparam int ST_TGT_LSB = 0;
	localparam int ST_ALARM_BIT = 2;
	localparam int ST_HOMED_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_CMDA_BIT = 5;
	localparam int ST_CMDB_BIT = 6;
	localparam int ST_ARR_LSB = 7;
	localparam int ST_ZONE_LSB = 10;
	localparam int EV_MOVE = 0;
	localparam int EV_ARRIVE = 1;
	localparam int EV_ALARM = 2;
	localparam int EV_HOME = 3;
	localparam logic [POS_W-1:0] RST_POS_START = 16'h0000;
	localparam logic [POS_W-1:0] RST_POS_END = 16'h1000;
	localparam logic [POS_W-1:0] RST_POS_MID = 16'h0800;
	localparam logic [POS_W-1:0] RST_WIDTH = 16'h0010;
	localparam logic [EV_W-1:0] RST_INT_MASK = 4'h0;
	typedef enum logic [1:0] {PAT_SINGLE, PAT_TWO_POINT, PAT_THREE_POINT} pat_t;
	typedef enum logic [2:0] {CMD_HOLD, CMD_START, CMD_END, CMD_MID, CMD_STOP} cmd_t;
	typedef enum logic [1:0] {PT_START, PT_END, PT_MID} pt_t;
endpackage

// file: verification/motion_stub.sv
`timescale 1ns/10ps
`default_nettype none
module motion_stub (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic move_start_out,
	input wire logic stop_out,
	input wire logic [15:0] target_pos_out,
	input wire logic [15:0] dly,
	output logic [15:0] cur_pos,
	output logic motion_busy,
	output logic move_complete
);
	logic [15:0] cnt_r;
	logic [15:0] tgt_r;
	// A slow travel time lets the bench land a stop in mid-move
	always_ff @(posedge clk) begin
		move_complete <= 1'b0;
		if (!rst_n) begin
			cur_pos <= 16'h0400;
			motion_busy <= 1'b0;
			cnt_r <= 16'h0000;
			tgt_r <= 16'h0000;
		end else if (stop_out) begin
			motion_busy <= 1'b0;
		end else if (move_start_out) begin
			motion_busy <= 1'b1;
			cnt_r <= dly;
			tgt_r <= target_pos_out;
		end else if (motion_busy) begin
			if (cnt_r == 16'h0000) begin
				motion_busy <= 1'b0;
				cur_pos <= tgt_r;
				move_complete <= 1'b1;
			end else begin
				cnt_r <= cnt_r - 16'h0001;
			end
		end
	end
endmodule // motion_stub
`default_nettype wire

// file: verification/pio_point_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pio_point_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic move_start_out,
	input wire logic stop_out,
	input wire logic motion_busy,
	input wire logic fault_event,
	input wire logic fault_n_out,
	input wire logic home_complete,
	input wire logic homing_done_out,
	input wire logic start_arrived_out,
	input wire logic end_arrived_out,
	input wire logic mid_arrived_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("bus access not answered");
	property p_stop_busy;
		stop_out |-> $past(motion_busy);
	endproperty
	a_stop_busy: assert property (p_stop_busy) else $error("stop while idle");
	property p_move_pulse;
		move_start_out |=> !move_start_out;
	endproperty
	a_move_pulse: assert property (p_move_pulse) else $error("move pulse too long");
	property p_fault_set;
		fault_event |=> !fault_n_out;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not flagged");
	property p_fault_rel;
		$rose(fault_n_out) |-> !$past(fault_event);
	endproperty
	a_fault_rel: assert property (p_fault_rel) else $error("fault cleared wrongly");
	property p_home;
		$rose(homing_done_out) |-> $past(home_complete);
	endproperty
	a_home: assert property (p_home) else $error("homing done too early");
	property p_arr_one;
		$onehot0({start_arrived_out, end_arrived_out, mid_arrived_out});
	endproperty
	a_arr_one: assert property (p_arr_one) else $error("two arrivals at once");
	c_move: cover property (move_start_out);
	c_stop: cover property (stop_out);
	c_alarm: cover property ($fell(fault_n_out));
endmodule // pio_point_chk
bind pio_point_move_interface pio_point_chk u_pio_point_chk (.clk, .rst_n, .avs_read,
	.avs_write, .avs_waitrequest, .move_start_out, .stop_out, .motion_busy, .fault_event,
	.fault_n_out, .home_complete, .homing_done_out, .start_arrived_out, .end_arrived_out,
	.mid_arrived_out);
`default_nettype wire

// file: verification/pio_point_move_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pio_point_move_interface_tb;
	import pio_point_pkg::*;
	logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, move_cmd_a = 0, move_cmd_b = 0;
	logic alarm_clear_in = 0, home_complete = 0, fault_event = 0;
	logic [ADDR_W-1:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hf;
	logic [POS_W-1:0] cur_pos, target_pos_out, dly = 16'h0014;
	logic avs_waitrequest, irq, motion_busy, move_complete, move_start_out, stop_out;
	logic start_zone_out, end_zone_out, mid_zone_out, homing_done_out, fault_n_out;
	logic start_arrived_out, end_arrived_out, mid_arrived_out;
	int err_count = 0, checked = 0;
	int moves = 0, stops = 0;
	always #2.5 clk = ~clk;
	// Pulses are counted as sampled at the edge, so a one-cycle pulse counts once
	always @(posedge clk) begin
		if (move_start_out === 1'b1) begin
			moves++;
		end
		if (stop_out === 1'b1) begin
			stops++;
		end
	end
	pio_point_move_interface u_pio_point_move_interface (.clk, .rst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .irq, .move_cmd_a, .move_cmd_b, .alarm_clear_in, .cur_pos,
		.motion_busy, .move_complete, .home_complete, .fault_event, .move_start_out,
		.target_pos_out, .stop_out, .start_zone_out, .end_zone_out, .mid_zone_out,
		.start_arrived_out, .end_arrived_out, .mid_arrived_out, .homing_done_out, .fault_n_out);
	motion_stub u_motion_stub (.clk, .rst_n, .move_start_out, .stop_out, .target_pos_out,
		.dly, .cur_pos, .motion_busy, .move_complete);
	task test_done;
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Waitrequest is taken as sampled at the rising edge; the request drops at that edge
	task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			test_done;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	// Long enough for the input filter plus a prompt move
	task pins(input logic a, input logic b);
		move_cmd_a <= a;
		move_cmd_b <= b;
		repeat (460) @(posedge clk);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(fault_n_out, 1'b1);
		bus(1'b0, OFS_POS_END, 32'h0);
		chk(q, {16'h0000, RST_POS_END});
		bus(1'b0, 5'h02, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, OFS_WIDTH, 32'h0020);
		bus(1'b0, OFS_WIDTH, 32'h0);
		chk(q, 32'h20);
		bus(1'b1, OFS_CTRL, 32'h8);
		pins(1'b0, 1'b0);
		chk(start_arrived_out, 1'b1);
		home_complete <= 1'b1;
		repeat (4) @(posedge clk);
		chk(homing_done_out, 1'b1);
		pins(1'b1, 1'b0);
		chk(target_pos_out, RST_POS_END);
		chk({start_arrived_out, end_arrived_out}, 2'b01);
		$display("single-input test done");
		bus(1'b1, OFS_CTRL, 32'h9);
		pins(1'b1, 1'b0);
		chk(start_arrived_out, 1'b1);
		pins(1'b0, 1'b1);
		chk(end_arrived_out, 1'b1);
		pins(1'b1, 1'b1);
		chk(target_pos_out, RST_POS_MID);
		chk(mid_arrived_out, 1'b1);
		$display("two-point test done");
		bus(1'b1, OFS_CTRL, 32'ha);
		@(posedge clk);
		chk(homing_done_out, 1'b0);
		dly <= 16'h0bb8;
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		chk({motion_busy, end_arrived_out}, 2'b00);
		dly <= 16'h0014;
		pins(1'b1, 1'b1);
		chk(mid_arrived_out, 1'b1);
		bus(1'b1, OFS_CTRL, 32'he);
		dly <= 16'h0bb8;
		pins(1'b0, 1'b1);
		pins(1'b1, 1'b1);
		chk({motion_busy, end_arrived_out}, 2'b00);
		chk(stops, 2);
		dly <= 16'h0014;
		pins(1'b0, 1'b0);
		chk(mid_arrived_out, 1'b1);
		bus(1'b1, OFS_CTRL, 32'h2);
		repeat (4) @(posedge clk);
		chk({start_zone_out, end_zone_out, mid_zone_out}, 3'b001);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(q, (32'h2 << ST_TGT_LSB) | (32'h1 << ST_HOMED_BIT) | (32'h4 << ST_ARR_LSB)
			| (32'h4 << ST_ZONE_LSB));
		chk(moves, 9);
		$display("three-point test done");
		bus(1'b1, OFS_INT_MASK, 32'h4);
		fault_event <= 1'b1;
		@(posedge clk);
		fault_event <= 1'b0;
		repeat (3) @(posedge clk);
		chk({fault_n_out, irq}, 2'b01);
		bus(1'b0, OFS_INT_STAT, 32'h0);
		chk(q, 32'hf);
		bus(1'b1, OFS_INT_STAT, 32'hf);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		bus(1'b0, OFS_INT_STAT, 32'h0);
		chk(q, 32'h0);
		alarm_clear_in <= 1'b1;
		repeat (460) @(posedge clk);
		chk(fault_n_out, 1'b1);
		$display("alarm test done");
		test_done;
	end
endmodule // pio_point_move_interface_tb
`default_nettype wire
